// ===== tws_pkg.sv
// Purpose: shared constants and types for the two-wire slave engine
// Assumes: 8-bit register port with four word slots, status codes in bits 7:3
// Notes: status codes are listed with the prescaler field at zero
package tws_pkg;
	// ********************************************************************
	// register offsets
	// ********************************************************************
	localparam logic [1:0] TWS_OFS_DATA = 2'h0;
	localparam logic [1:0] TWS_OFS_ADDR = 2'h1;
	localparam logic [1:0] TWS_OFS_STATUS = 2'h2;
	localparam logic [1:0] TWS_OFS_CTRL = 2'h3;

	// ********************************************************************
	// field positions, reset values and bit counter marks
	// ********************************************************************
	localparam int TWS_CTRL_FLAG = 7;
	localparam int TWS_ADDR_GC = 0;
	localparam logic [7:0] TWS_RST_CTRL = 8'h00;
	localparam logic [7:0] TWS_RST_ADDR = 8'h00;
	localparam logic [7:0] TWS_RST_DATA = 8'hFF;
	localparam logic [1:0] TWS_RST_PRESC = 2'h0;
	localparam logic [3:0] TWS_LAST_BIT = 4'h7;
	localparam logic [3:0] TWS_ACK_BIT = 4'h8;
	localparam logic [3:0] TWS_ACK_HELD = 4'h9;

	// ********************************************************************
	// status codes
	// ********************************************************************
	localparam logic [7:0] TWS_ST_SR_ADDR = 8'h60;
	localparam logic [7:0] TWS_ST_SR_ADDR_ARB = 8'h68;
	localparam logic [7:0] TWS_ST_SR_GC = 8'h70;
	localparam logic [7:0] TWS_ST_SR_GC_ARB = 8'h78;
	localparam logic [7:0] TWS_ST_SR_DATA_ACK = 8'h80;
	localparam logic [7:0] TWS_ST_SR_DATA_NACK = 8'h88;
	localparam logic [7:0] TWS_ST_GC_DATA_ACK = 8'h90;
	localparam logic [7:0] TWS_ST_GC_DATA_NACK = 8'h98;
	localparam logic [7:0] TWS_ST_STOP_RESTART = 8'hA0;
	localparam logic [7:0] TWS_ST_ST_ADDR = 8'hA8;
	localparam logic [7:0] TWS_ST_ST_ADDR_ARB = 8'hB0;
	localparam logic [7:0] TWS_ST_ST_DATA_ACK = 8'hB8;
	localparam logic [7:0] TWS_ST_ST_DATA_NACK = 8'hC0;
	localparam logic [7:0] TWS_ST_ST_LAST_ACK = 8'hC8;
	localparam logic [7:0] TWS_ST_NO_INFO = 8'hF8;

	// ********************************************************************
	// types
	// ********************************************************************
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tws_bus_s;

	typedef struct packed {
		logic ack_enable;
		logic start_request;
		logic stop_request;
		logic interface_enable;
		logic interrupt_enable;
	} tws_ctrl_s;

	typedef enum {
		TWS_IDLE,
		TWS_IGNORE,
		TWS_ADDR_RX,
		TWS_ADDR_ACK,
		TWS_RX,
		TWS_RX_ACK,
		TWS_TX,
		TWS_TX_ACK,
		TWS_DONE
	} tws_state_e;
endpackage : tws_pkg

// ===== tws_engine.sv
// Purpose: slave receiver and transmitter engine of a byte-oriented two-wire interface
// Assumes: scl_i and sda_i are asynchronous pins, sampled well above the bus bit rate
// Notes: master modes and bus-error recovery are not part of this block
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module tws_engine
	import tws_pkg::*;
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire tws_bus_s bus_i,
	output logic [7:0] rdata_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oen_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oen_o,
	input wire logic sleep_i,
	input wire logic arb_lost_i,
	output logic wake_o,
	output logic master_start_o
);
	// ********************************************************************
	// pin synchronisers and bus events
	// ********************************************************************
	logic scl_sync, scl_prev;
	logic sda_sync, sda_prev;

	// bus idles high, so the stages reset high and no false edge follows reset
	tws_pin_sync u_scl_sync (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.pin_i(scl_i),
		.sync_o(scl_sync),
		.prev_o(scl_prev)
	);
	tws_pin_sync u_sda_sync (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.pin_i(sda_i),
		.sync_o(sda_sync),
		.prev_o(sda_prev)
	);

	wire scl_rise = scl_sync & ~scl_prev;
	wire scl_fall = ~scl_sync & scl_prev;
	wire start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
	wire stop_seen = scl_sync & scl_prev & ~sda_prev & sda_sync;

	// ********************************************************************
	// registers and decode
	// ********************************************************************
	tws_ctrl_s ctrl;
	logic [7:0] own_addr;
	logic [7:0] data;
	logic [7:0] status;
	logic [1:0] presc;
	logic flag;
	logic wcol;
	tws_state_e state;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic sda_drv;
	logic read_dir, gc_mode, arb_pend, rx_ack, master_ack, tx_last, busy;

	wire wr_ctrl = bus_i.wr & (bus_i.addr == TWS_OFS_CTRL);
	wire wr_data = bus_i.wr & (bus_i.addr == TWS_OFS_DATA);
	wire wr_addr = bus_i.wr & (bus_i.addr == TWS_OFS_ADDR);
	wire wr_stat = bus_i.wr & (bus_i.addr == TWS_OFS_STATUS);
	wire flag_clr = wr_ctrl & bus_i.wdata[TWS_CTRL_FLAG];
	wire ack_now = wr_ctrl ? bus_i.wdata[6] : ctrl.ack_enable;

	wire [7:0] addr_byte = {shreg[6:0], sda_sync};
	wire own_hit = addr_byte[7:1] == own_addr[7:1];
	wire gc_hit = (addr_byte[7:1] == 7'h00) & own_addr[TWS_ADDR_GC] & ~addr_byte[0];
	// no match while the flag still waits, so an unanswered status is never overwritten
	wire addr_hit = (own_hit | gc_hit) & ctrl.ack_enable & ~flag;
	wire addressed = (state == TWS_ADDR_ACK) | (state == TWS_RX) | (state == TWS_RX_ACK)
		| (state == TWS_TX) | (state == TWS_TX_ACK);
	wire stretch = flag & ((state == TWS_RX) | (state == TWS_TX)
		| ((state == TWS_DONE) & (status != TWS_ST_STOP_RESTART)));

	wire [7:0] addr_code = read_dir ? (arb_pend ? TWS_ST_ST_ADDR_ARB : TWS_ST_ST_ADDR)
		: gc_mode ? (arb_pend ? TWS_ST_SR_GC_ARB : TWS_ST_SR_GC)
		: (arb_pend ? TWS_ST_SR_ADDR_ARB : TWS_ST_SR_ADDR);
	wire [7:0] rx_code = gc_mode ? (rx_ack ? TWS_ST_GC_DATA_ACK : TWS_ST_GC_DATA_NACK)
		: (rx_ack ? TWS_ST_SR_DATA_ACK : TWS_ST_SR_DATA_NACK);
	wire [7:0] tx_code = ~master_ack ? TWS_ST_ST_DATA_NACK
		: (tx_last ? TWS_ST_ST_LAST_ACK : TWS_ST_ST_DATA_ACK);
	// status field reads no-info while no flag is pending; prescaler sits below it
	wire [7:0] stat_code = flag ? status : TWS_ST_NO_INFO;
	wire [7:0] stat_read = {stat_code[7:3], 1'b0, presc};
	wire [7:0] ctrl_read = {flag, ctrl.ack_enable, ctrl.start_request, ctrl.stop_request,
		wcol, ctrl.interface_enable, 1'b0, ctrl.interrupt_enable};
	wire [7:0] rd_mux = (bus_i.addr == TWS_OFS_DATA) ? data
		: (bus_i.addr == TWS_OFS_ADDR) ? own_addr
		: (bus_i.addr == TWS_OFS_STATUS) ? stat_read : ctrl_read;

	// ********************************************************************
	// software-side registers
	// ********************************************************************
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			ctrl <= tws_ctrl_s'(5'h00);
			own_addr <= TWS_RST_ADDR;
			presc <= TWS_RST_PRESC;
			wcol <= TWS_RST_CTRL[3];
		end else begin
			if (wr_ctrl) begin
				ctrl.ack_enable <= bus_i.wdata[6];
				ctrl.start_request <= bus_i.wdata[5];
				// stop has no slave meaning; it is only stored and read back
				ctrl.stop_request <= bus_i.wdata[4];
				ctrl.interface_enable <= bus_i.wdata[2];
				ctrl.interrupt_enable <= bus_i.wdata[0];
			end
			if (wr_addr) begin
				own_addr <= bus_i.wdata;
			end
			if (wr_stat) begin
				presc <= bus_i.wdata[1:0];
			end
			// collision set wins over the clear by a control write
			if (wr_data & ~flag) begin
				wcol <= 1'b1;
			end else if (wr_ctrl) begin
				wcol <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= bus_i.rd ? rd_mux : 8'h00;
		end
	end

	// ********************************************************************
	// bus engine
	// ********************************************************************
	always_ff @(posedge clock_i) begin
		if (!nrst_i || !ctrl.interface_enable) begin
			state <= TWS_IDLE;
			bitcnt <= 4'h0;
			shreg <= TWS_RST_DATA;
			sda_drv <= 1'b0;
			flag <= 1'b0;
			status <= TWS_ST_NO_INFO;
			read_dir <= 1'b0;
			gc_mode <= 1'b0;
			rx_ack <= 1'b0;
			master_ack <= 1'b0;
			tx_last <= 1'b0;
			if (!nrst_i) begin
				data <= TWS_RST_DATA;
				arb_pend <= 1'b0;
			end
		end else begin
			if (flag_clr) begin
				flag <= 1'b0;
			end
			if (wr_data & flag) begin
				data <= bus_i.wdata;
			end
			if (arb_lost_i) begin
				arb_pend <= 1'b1;
			end
			if (start_seen) begin
				if (addressed) begin
					flag <= 1'b1;
					status <= TWS_ST_STOP_RESTART;
				end
				state <= TWS_ADDR_RX;
				bitcnt <= 4'h0;
				sda_drv <= 1'b0;
			end else if (stop_seen) begin
				if (addressed) begin
					flag <= 1'b1;
					status <= TWS_ST_STOP_RESTART;
					state <= TWS_DONE;
				end else if (state != TWS_DONE) begin
					state <= TWS_IDLE;
				end
				sda_drv <= 1'b0;
			end else begin
				case (state)
					TWS_ADDR_RX: begin
						if (scl_rise) begin
							shreg <= addr_byte;
							bitcnt <= bitcnt + 4'h1;
							if (bitcnt == TWS_LAST_BIT) begin
								read_dir <= addr_byte[0];
								gc_mode <= ~own_hit;
								state <= addr_hit ? TWS_ADDR_ACK : TWS_IGNORE;
							end
						end
					end
					TWS_ADDR_ACK: begin
						if (scl_fall) begin
							if (!sda_drv) begin
								sda_drv <= 1'b1;
							end else begin
								sda_drv <= 1'b0;
								flag <= 1'b1;
								status <= addr_code;
								arb_pend <= 1'b0;
								bitcnt <= 4'h0;
								state <= read_dir ? TWS_TX : TWS_RX;
							end
						end
					end
					TWS_RX: begin
						if (scl_rise) begin
							shreg <= addr_byte;
							bitcnt <= bitcnt + 4'h1;
							if (bitcnt == TWS_LAST_BIT) begin
								// bus bytes seen in deep sleep are not kept
								if (!sleep_i) begin
									data <= addr_byte;
								end
								rx_ack <= ctrl.ack_enable;
								state <= TWS_RX_ACK;
							end
						end
					end
					TWS_RX_ACK: begin
						if (scl_fall) begin
							if (bitcnt == TWS_ACK_BIT) begin
								bitcnt <= TWS_ACK_HELD;
								sda_drv <= rx_ack;
							end else begin
								sda_drv <= 1'b0;
								flag <= 1'b1;
								status <= rx_code;
								bitcnt <= 4'h0;
								state <= rx_ack ? TWS_RX : TWS_DONE;
							end
						end
					end
					TWS_TX: begin
						if (flag_clr & flag) begin
							// first bit goes out together with the scl release
							shreg <= data;
							tx_last <= ~ack_now;
							sda_drv <= ~data[7];
							bitcnt <= 4'h0;
						end else if (scl_fall & ~flag) begin
							if (bitcnt == TWS_LAST_BIT) begin
								sda_drv <= 1'b0;
								bitcnt <= TWS_ACK_BIT;
								state <= TWS_TX_ACK;
							end else begin
								shreg <= {shreg[6:0], 1'b1};
								sda_drv <= ~shreg[6];
								bitcnt <= bitcnt + 4'h1;
							end
						end
					end
					TWS_TX_ACK: begin
						// the master's answer is taken once, at the rise of the ack bit
						if (scl_rise & (bitcnt == TWS_ACK_BIT)) begin
							master_ack <= ~sda_sync;
							bitcnt <= TWS_ACK_HELD;
						end else if (scl_fall & (bitcnt == TWS_ACK_HELD)) begin
							flag <= 1'b1;
							status <= tx_code;
							bitcnt <= 4'h0;
							// after the last byte the master only reads released sda
							state <= (master_ack & ~tx_last) ? TWS_TX : TWS_DONE;
						end
					end
					TWS_DONE: begin
						if (flag_clr) begin
							state <= TWS_IDLE;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ********************************************************************
	// pins, wake-up and start request
	// ********************************************************************
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			sda_o <= 1'b0;
			scl_o <= 1'b0;
			sda_oen_o <= 1'b1;
			scl_oen_o <= 1'b1;
			busy <= 1'b0;
			wake_o <= 1'b0;
			master_start_o <= 1'b0;
		end else begin
			// open-drain: only the enables move, the driven level is always low
			sda_o <= 1'b0;
			scl_o <= 1'b0;
			// enables are registered so the pins never glitch from decode
			sda_oen_o <= ~(sda_drv & ctrl.interface_enable);
			scl_oen_o <= ~(stretch & ctrl.interface_enable);
			if (start_seen) begin
				busy <= 1'b1;
			end else if (stop_seen) begin
				busy <= 1'b0;
			end
			// the match is acked from bus edges alone, then the part is woken
			if (!sleep_i) begin
				wake_o <= 1'b0;
			end else if ((state == TWS_ADDR_ACK) & sda_drv & scl_fall) begin
				wake_o <= 1'b1;
			end
			master_start_o <= ctrl.start_request & ctrl.interface_enable & ~busy & ~flag
				& (state == TWS_IDLE);
		end
	end
endmodule : tws_engine

// ********************************************************************
// pin synchroniser
// ********************************************************************
// two flops guard against metastability; the third stage only feeds the
// edge detectors, so nothing reads the first flop but the second
module tws_pin_sync
	import tws_pkg::*;
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic pin_i,
	output logic sync_o,
	output logic prev_o
);
	logic meta;

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			meta <= 1'b1;
			sync_o <= 1'b1;
			prev_o <= 1'b1;
		end else begin
			meta <= pin_i;
			sync_o <= meta;
			prev_o <= sync_o;
		end
	end
endmodule : tws_pin_sync

// ===== tws_engine_asserts.sv
// Purpose: port-level checks of the two-wire slave engine
// Assumes: one clock domain, nrst_i synchronous active low
// Notes: flag state is inferred from clock stretching and control writes
`timescale 1ns/1ps
module tws_engine_asserts
	import tws_pkg::*;
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire tws_bus_s bus_i,
	input wire logic [7:0] rdata_o,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oen_o,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oen_o,
	input wire logic sleep_i,
	input wire logic arb_lost_i,
	input wire logic wake_o,
	input wire logic master_start_o
);
	wire ctrl_wr = bus_i.wr && bus_i.addr == TWS_OFS_CTRL;
	wire clear_wr = ctrl_wr && bus_i.wdata[TWS_CTRL_FLAG] && bus_i.wdata[2];
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	// ********************************************************************
	// assertions
	// ********************************************************************
	a_rdata_quiet: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_status_gap_bit: assert property ($past(bus_i.rd) && $past(bus_i.addr) == TWS_OFS_STATUS |-> !rdata_o[2])
		else $error("status bit 2 not zero");
	a_stretch_hold: assert property (!scl_oen_o && !ctrl_wr && !$past(ctrl_wr) |=> !scl_oen_o)
		else $error("clock released without a control write");
	a_clear_release: assert property (clear_wr && !scl_oen_o |-> ##[1:2] scl_oen_o)
		else $error("clock not released after flag clear");
	a_wake_cause: assert property ($rose(wake_o) |-> $past(sleep_i))
		else $error("wake raised outside sleep");
	a_wake_drop: assert property (!sleep_i |=> !wake_o)
		else $error("wake held while awake");
	a_wake_stretch: assert property ($rose(wake_o) |-> ##[0:40] !scl_oen_o)
		else $error("clock not held after wake match");
	a_start_idle: assert property (master_start_o |-> scl_oen_o && sda_oen_o)
		else $error("start request while driving the bus");
	c_stretch: cover property ($fell(scl_oen_o));
	c_wake: cover property ($rose(wake_o));
	c_start: cover property ($rose(master_start_o));
endmodule : tws_engine_asserts

bind tws_engine tws_engine_asserts u_asserts (.clock_i(clock_i), .nrst_i(nrst_i), .bus_i(bus_i),
	.rdata_o(rdata_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oen_o(scl_oen_o), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oen_o(sda_oen_o), .sleep_i(sleep_i), .arb_lost_i(arb_lost_i), .wake_o(wake_o),
	.master_start_o(master_start_o));

// ===== tws_bus_master_model.sv
// Purpose: behavioural two-wire bus master for the slave engine bench
// Assumes: open-drain lines with pull-ups, 800 ns bit period
// Notes: outputs are 1 to release a line, 0 to pull it low
`timescale 1ns/1ps
module tws_bus_master_model (
	input wire logic clock_i,
	output logic scl_drv_o,
	output logic sda_drv_o,
	input wire logic scl_i,
	input wire logic sda_i
);
	initial begin
		scl_drv_o = 1'b1;
		sda_drv_o = 1'b1;
	end
	// lines move on falling edges, away from the edge that samples them
	task automatic gap(input int n);
		repeat (n) @(negedge clock_i);
	endtask : gap
	// waiting on the wire lets the slave stretch as long as it likes
	task automatic bit_cycle(input logic b, output logic r);
		sda_drv_o = b;
		gap(2);
		scl_drv_o = 1'b1;
		wait (scl_i);
		gap(2);
		r = sda_i;
		gap(2);
		scl_drv_o = 1'b0;
		gap(2);
	endtask : bit_cycle
	task automatic start;
		gap(1);
		sda_drv_o = 1'b1;
		gap(2);
		scl_drv_o = 1'b1;
		wait (scl_i);
		gap(4);
		sda_drv_o = 1'b0;
		gap(4);
		scl_drv_o = 1'b0;
		gap(2);
	endtask : start
	// clock stands still high after a stop
	task automatic stop;
		gap(1);
		sda_drv_o = 1'b0;
		gap(2);
		scl_drv_o = 1'b1;
		wait (scl_i);
		gap(4);
		sda_drv_o = 1'b1;
		gap(4);
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
		gap(1);
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(d[i], q[i]);
		end
		bit_cycle(ack_in, ack_out);
	endtask : xfer
endmodule : tws_bus_master_model

// ===== testbench.sv
// Purpose: self-checking bench of the two-wire slave engine
// Assumes: 10 MHz system clock, bus master model on the pins
// Notes: status reads are masked to hide the prescaler field
`timescale 1ns/1ps
module testbench
	import tws_pkg::*;
;
	localparam logic [7:0] OWN_WR = 8'h54;
	localparam logic [7:0] OWN_RD = 8'h55;
	localparam logic [7:0] C_IDLE = 8'h44;
	localparam logic [7:0] C_GO = 8'hC4;
	localparam logic [7:0] C_NOACK = 8'h84;
	localparam logic [7:0] C_ISO = 8'h04;
	localparam logic [7:0] C_RESTART = 8'hA4;
	logic clock = 1'b0;
	logic nrst;
	logic sleep;
	logic arb_lost;
	tws_bus_s bus;
	logic [7:0] rdata;
	logic scl_oen, scl_out, sda_oen, sda_out, wake, master_start, scl_drv, sda_drv;
	wire scl_line = scl_drv & (scl_oen | scl_out);
	wire sda_line = sda_drv & (sda_oen | sda_out);
	int mismatches;
	int n_checks;
	always #50 clock = ~clock;
	tws_engine dut (.clock_i(clock), .nrst_i(nrst), .bus_i(bus), .rdata_o(rdata), .scl_i(scl_line),
		.scl_o(scl_out), .scl_oen_o(scl_oen), .sda_i(sda_line), .sda_o(sda_out), .sda_oen_o(sda_oen),
		.sleep_i(sleep), .arb_lost_i(arb_lost), .wake_o(wake), .master_start_o(master_start));
	tws_bus_master_model m (.clock_i(clock), .scl_drv_o(scl_drv), .sda_drv_o(sda_drv), .scl_i(scl_line),
		.sda_i(sda_line));
	// ********************************************************************
	// bus and check tasks
	// ********************************************************************
	task automatic wrap_up;
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] q);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 q = rdata;
	endtask : rd
	task automatic rchk(input logic [1:0] a, input logic [7:0] e);
		logic [7:0] q;
		rd(a, q);
		if (a == TWS_OFS_STATUS) begin
			q = q & 8'hF8;
		end
		chk("register read", q, e);
	endtask : rchk
	// polls the flag, then compares the status code
	task automatic st(input logic [7:0] e);
		logic [7:0] q;
		q = 8'h00;
		for (int i = 0; i < 400 && q[TWS_CTRL_FLAG] !== 1'b1; i++) begin
			rd(TWS_OFS_CTRL, q);
		end
		chk("interrupt flag", q & 8'h80, 8'h80);
		rchk(TWS_OFS_STATUS, e);
	endtask : st
	task automatic mx(input logic s, input logic [7:0] d, input logic ack_in, input logic [7:0] e, input logic rx);
		logic [7:0] q;
		logic k;
		if (s) begin
			m.start();
		end
		m.xfer(d, ack_in, q, k);
		if (rx) begin
			chk("byte read", q, e);
		end else begin
			chk("acknowledge", {7'h00, k}, e);
		end
	endtask : mx
	// ********************************************************************
	// scenarios
	// ********************************************************************
	initial begin
		mismatches = 0;
		n_checks = 0;
		nrst = 1'b0;
		sleep = 1'b0;
		arb_lost = 1'b0;
		bus = '0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		rchk(TWS_OFS_CTRL, TWS_RST_CTRL);
		rchk(TWS_OFS_ADDR, TWS_RST_ADDR);
		rchk(TWS_OFS_DATA, TWS_RST_DATA);
		rchk(TWS_OFS_STATUS, TWS_ST_NO_INFO);
		wr(TWS_OFS_ADDR, OWN_RD);
		wr(TWS_OFS_CTRL, C_IDLE);
		mx(1'b1, OWN_RD, 1'b1, 8'h00, 1'b0);
		st(TWS_ST_ST_ADDR);
		wr(TWS_OFS_DATA, 8'hA5);
		wr(TWS_OFS_CTRL, C_GO);
		mx(1'b0, 8'hFF, 1'b0, 8'hA5, 1'b1);
		st(TWS_ST_ST_DATA_ACK);
		wr(TWS_OFS_DATA, 8'h3C);
		wr(TWS_OFS_CTRL, C_NOACK);
		mx(1'b0, 8'hFF, 1'b0, 8'h3C, 1'b1);
		st(TWS_ST_ST_LAST_ACK);
		wr(TWS_OFS_CTRL, C_GO);
		mx(1'b0, 8'hFF, 1'b1, 8'hFF, 1'b1);
		m.stop();
		rchk(TWS_OFS_STATUS, TWS_ST_NO_INFO);
		mx(1'b1, 8'h00, 1'b1, 8'h00, 1'b0);
		st(TWS_ST_SR_GC);
		wr(TWS_OFS_CTRL, C_GO);
		mx(1'b0, 8'h12, 1'b1, 8'h00, 1'b0);
		st(TWS_ST_GC_DATA_ACK);
		rchk(TWS_OFS_DATA, 8'h12);
		wr(TWS_OFS_CTRL, C_NOACK);
		mx(1'b0, 8'h34, 1'b1, 8'h01, 1'b0);
		st(TWS_ST_GC_DATA_NACK);
		wr(TWS_OFS_CTRL, C_GO);
		m.stop();
		rchk(TWS_OFS_STATUS, TWS_ST_NO_INFO);
		wr(TWS_OFS_CTRL, C_ISO);
		mx(1'b1, OWN_WR, 1'b1, 8'h01, 1'b0);
		m.stop();
		wr(TWS_OFS_CTRL, C_IDLE);
		mx(1'b1, OWN_WR, 1'b1, 8'h00, 1'b0);
		st(TWS_ST_SR_ADDR);
		wr(TWS_OFS_CTRL, C_GO);
		m.start();
		st(TWS_ST_STOP_RESTART);
		wr(TWS_OFS_CTRL, C_GO);
		m.stop();
		wr(TWS_OFS_ADDR, OWN_WR);
		mx(1'b1, 8'h00, 1'b1, 8'h01, 1'b0);
		m.stop();
		@(posedge clock) arb_lost <= 1'b1;
		@(posedge clock) arb_lost <= 1'b0;
		mx(1'b1, OWN_RD, 1'b1, 8'h00, 1'b0);
		st(TWS_ST_ST_ADDR_ARB);
		wr(TWS_OFS_DATA, 8'h81);
		wr(TWS_OFS_CTRL, C_NOACK);
		mx(1'b0, 8'hFF, 1'b1, 8'h81, 1'b1);
		st(TWS_ST_ST_DATA_NACK);
		wr(TWS_OFS_CTRL, C_RESTART);
		@(negedge clock);
		chk("start request", {7'h00, master_start}, 8'h00);
		m.stop();
		for (int i = 0; i < 50 && master_start !== 1'b1; i++) begin
			@(negedge clock);
		end
		chk("start request", {7'h00, master_start}, 8'h01);
		wr(TWS_OFS_CTRL, C_IDLE);
		@(posedge clock) sleep <= 1'b1;
		mx(1'b1, OWN_WR, 1'b1, 8'h00, 1'b0);
		repeat (4) @(negedge clock);
		chk("wake", {7'h00, wake}, 8'h01);
		st(TWS_ST_SR_ADDR);
		wr(TWS_OFS_CTRL, C_GO);
		mx(1'b0, 8'h5A, 1'b1, 8'h00, 1'b0);
		st(TWS_ST_SR_DATA_ACK);
		rchk(TWS_OFS_DATA, 8'h81);
		@(posedge clock) sleep <= 1'b0;
		wr(TWS_OFS_CTRL, C_GO);
		m.stop();
		st(TWS_ST_STOP_RESTART);
		wr(TWS_OFS_CTRL, C_GO);
		wrap_up();
	end
	// well over ten times the expected run of some hundred and fifty microseconds
	initial begin
		#2_000_000;
		mismatches++;
		wrap_up();
	end
endmodule : testbench
